// [common/jtapp_cfg.svh]
// Constants for the boundary-scan test access port
`ifndef JTAPP_CFG_SVH
`define JTAPP_CFG_SVH

`define JTAPP_IR_WIDTH      4
`define JTAPP_DR_WIDTH      32
`define JTAPP_IR_CAPTURE    4'h1
`define JTAPP_INSN_IDCODE   4'h1
`define JTAPP_INSN_BYPASS   4'hf
// Identity value is arbitrary; bit 0 must stay one
`define JTAPP_IDCODE_VALUE  32'h0a5a5001
// Level the pin synchronisers and edge detector load at reset
`define JTAPP_PIN_DEFAULT   1'b1

`endif

// [common/jtapp_pkg.sv]
// Types for the boundary-scan test access port
package jtapp_pkg;

    typedef enum logic [3:0] {
        JTAPP_TLR       = 4'h0,
        JTAPP_IDLE      = 4'h1,
        JTAPP_SEL_DR    = 4'h2,
        JTAPP_CAP_DR    = 4'h3,
        JTAPP_SHIFT_DR  = 4'h4,
        JTAPP_EXIT1_DR  = 4'h5,
        JTAPP_PAUSE_DR  = 4'h6,
        JTAPP_EXIT2_DR  = 4'h7,
        JTAPP_UPD_DR    = 4'h8,
        JTAPP_SEL_IR    = 4'h9,
        JTAPP_CAP_IR    = 4'ha,
        JTAPP_SHIFT_IR  = 4'hb,
        JTAPP_EXIT1_IR  = 4'hc,
        JTAPP_PAUSE_IR  = 4'hd,
        JTAPP_EXIT2_IR  = 4'he,
        JTAPP_UPD_IR    = 4'hf
    } jtapp_state_t;

endpackage

// [hw/jtapp_sync.sv]
// Two-flop synchroniser with a constant reset level
`timescale 1ns/100ps
`default_nettype none

module jtapp_sync
#(
    parameter logic RESET_VAL = 1'b1
)
(
    input  wire logic i_clock,
    input  wire logic i_reset_n,
    input  wire logic i_async,
    output var  logic o_sync
);

    logic meta_reg;

    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            meta_reg <= RESET_VAL;
            o_sync   <= RESET_VAL;
        end
        else
        begin
            meta_reg <= i_async;
            o_sync   <= meta_reg;
        end
    end

endmodule

`default_nettype wire

// [hw/jtapp_tap.sv]
// Boundary-scan test access port: pin sampling, sixteen-state controller, IR and data registers
//
// How it works
// RULE1: Test data input is shifted in on each rising test clock edge.
// RULE2: Mode select sampled on rising test clock edge alone steers the state machine.
// RULE3: All test logic advances only on edges of the external test clock.
// RULE4: Test data output changes only on falling test clock edges.
// RULE5: Output driven both levels only while enabled, otherwise released.
// RULE6: Low test reset forces test-logic-reset asynchronously; held low at power-up.
// RULE7: Outside party keeps test reset low in normal use or permanently.
// RULE8: Unconnected test inputs read as logic high. Code only resets the pin synchronisers high; no pull-up.
// RULE9: Standard sixteen-state controller with instruction and data register scans.
`include "jtapp_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module jtapp_tap
(
    input  wire logic i_clock,
    input  wire logic i_reset_n,
    input  wire logic i_tck,
    input  wire logic i_tms,
    input  wire logic i_tdi,
    input  wire logic i_trst_n,
    output var  logic o_tdo,
    output var  logic o_tdo_oe,
    output var  logic o_tap_reset
);

    logic                        tck_sync;
    logic                        tms_sync;
    logic                        tdi_sync;
    logic                        tck_prev_reg;
    logic                        tck_rise;
    logic                        tck_fall;
    logic                        trst_meta_reg;
    logic                        tap_rst_n_reg;
    logic                        tap_clr_n;
    jtapp_pkg::jtapp_state_t     state_reg;
    jtapp_pkg::jtapp_state_t     state_next;
    logic [`JTAPP_IR_WIDTH-1:0]  ir_shift_reg;
    logic [`JTAPP_IR_WIDTH-1:0]  ir_reg;
    logic [`JTAPP_DR_WIDTH-1:0]  dr_shift_reg;
    logic                        bypass_reg;
    logic                        sel_idcode;
    logic                        tdo_next;
    logic                        shifting;

    // Pins are async to i_clock; synchronisers hold the high default only while i_reset_n is low [RULE8]
    jtapp_sync #(.RESET_VAL(`JTAPP_PIN_DEFAULT)) u_sync_tck
    (
        .i_clock   (i_clock),
        .i_reset_n (i_reset_n),
        .i_async   (i_tck),
        .o_sync    (tck_sync)
    );

    jtapp_sync #(.RESET_VAL(`JTAPP_PIN_DEFAULT)) u_sync_tms
    (
        .i_clock   (i_clock),
        .i_reset_n (i_reset_n),
        .i_async   (i_tms),
        .o_sync    (tms_sync)
    );

    jtapp_sync #(.RESET_VAL(`JTAPP_PIN_DEFAULT)) u_sync_tdi
    (
        .i_clock   (i_clock),
        .i_reset_n (i_reset_n),
        .i_async   (i_tdi),
        .o_sync    (tdi_sync)
    );

    // Test reset asserts at once, releases after two clocks to avoid a ragged exit [RULE6]
    assign tap_clr_n = i_reset_n & i_trst_n;

    always_ff @(posedge i_clock or negedge tap_clr_n)
    begin
        if (!tap_clr_n)
        begin
            trst_meta_reg <= 1'b0;
            tap_rst_n_reg <= 1'b0;
        end
        else
        begin
            trst_meta_reg <= 1'b1;
            tap_rst_n_reg <= trst_meta_reg;
        end
    end

    // Edges of the test clock found from its synchronised copy [RULE3]
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            tck_prev_reg <= `JTAPP_PIN_DEFAULT;
        end
        else
        begin
            tck_prev_reg <= tck_sync;
        end
    end

    assign tck_rise = tck_sync & ~tck_prev_reg;
    assign tck_fall = ~tck_sync & tck_prev_reg;

    // Next state depends only on the sampled mode select [RULE2] [RULE9]
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            jtapp_pkg::JTAPP_TLR:      state_next = tms_sync ? jtapp_pkg::JTAPP_TLR    : jtapp_pkg::JTAPP_IDLE;
            jtapp_pkg::JTAPP_IDLE:     state_next = tms_sync ? jtapp_pkg::JTAPP_SEL_DR : jtapp_pkg::JTAPP_IDLE;
            jtapp_pkg::JTAPP_SEL_DR:   state_next = tms_sync ? jtapp_pkg::JTAPP_SEL_IR : jtapp_pkg::JTAPP_CAP_DR;
            jtapp_pkg::JTAPP_CAP_DR:   state_next = tms_sync ? jtapp_pkg::JTAPP_EXIT1_DR : jtapp_pkg::JTAPP_SHIFT_DR;
            jtapp_pkg::JTAPP_SHIFT_DR: state_next = tms_sync ? jtapp_pkg::JTAPP_EXIT1_DR : jtapp_pkg::JTAPP_SHIFT_DR;
            jtapp_pkg::JTAPP_EXIT1_DR: state_next = tms_sync ? jtapp_pkg::JTAPP_UPD_DR : jtapp_pkg::JTAPP_PAUSE_DR;
            jtapp_pkg::JTAPP_PAUSE_DR: state_next = tms_sync ? jtapp_pkg::JTAPP_EXIT2_DR : jtapp_pkg::JTAPP_PAUSE_DR;
            jtapp_pkg::JTAPP_EXIT2_DR: state_next = tms_sync ? jtapp_pkg::JTAPP_UPD_DR : jtapp_pkg::JTAPP_SHIFT_DR;
            jtapp_pkg::JTAPP_UPD_DR:   state_next = tms_sync ? jtapp_pkg::JTAPP_SEL_DR : jtapp_pkg::JTAPP_IDLE;
            jtapp_pkg::JTAPP_SEL_IR:   state_next = tms_sync ? jtapp_pkg::JTAPP_TLR    : jtapp_pkg::JTAPP_CAP_IR;
            jtapp_pkg::JTAPP_CAP_IR:   state_next = tms_sync ? jtapp_pkg::JTAPP_EXIT1_IR : jtapp_pkg::JTAPP_SHIFT_IR;
            jtapp_pkg::JTAPP_SHIFT_IR: state_next = tms_sync ? jtapp_pkg::JTAPP_EXIT1_IR : jtapp_pkg::JTAPP_SHIFT_IR;
            jtapp_pkg::JTAPP_EXIT1_IR: state_next = tms_sync ? jtapp_pkg::JTAPP_UPD_IR : jtapp_pkg::JTAPP_PAUSE_IR;
            jtapp_pkg::JTAPP_PAUSE_IR: state_next = tms_sync ? jtapp_pkg::JTAPP_EXIT2_IR : jtapp_pkg::JTAPP_PAUSE_IR;
            jtapp_pkg::JTAPP_EXIT2_IR: state_next = tms_sync ? jtapp_pkg::JTAPP_UPD_IR : jtapp_pkg::JTAPP_SHIFT_IR;
            jtapp_pkg::JTAPP_UPD_IR:   state_next = tms_sync ? jtapp_pkg::JTAPP_SEL_DR : jtapp_pkg::JTAPP_IDLE;
            default:                   state_next = jtapp_pkg::JTAPP_TLR;
        endcase
    end

    // State moves only on a rising test clock edge or to test-logic-reset at test reset [RULE2] [RULE3]
    always_ff @(posedge i_clock or negedge tap_rst_n_reg)
    begin
        if (!tap_rst_n_reg)
        begin
            state_reg <= jtapp_pkg::JTAPP_TLR; // [RULE6]
        end
        else if (tck_rise)
        begin
            state_reg <= state_next;
        end
    end

    // Instruction register: capture fixed pattern, shift, update; reset selects identity [RULE9]
    always_ff @(posedge i_clock or negedge tap_rst_n_reg)
    begin
        if (!tap_rst_n_reg)
        begin
            ir_shift_reg <= `JTAPP_IR_CAPTURE;
            ir_reg       <= `JTAPP_INSN_IDCODE;
        end
        else if (tck_rise)
        begin
            case (state_reg)
                jtapp_pkg::JTAPP_TLR:      ir_reg <= `JTAPP_INSN_IDCODE;
                jtapp_pkg::JTAPP_CAP_IR:   ir_shift_reg <= `JTAPP_IR_CAPTURE;
                jtapp_pkg::JTAPP_SHIFT_IR: ir_shift_reg <= {tdi_sync, ir_shift_reg[`JTAPP_IR_WIDTH-1:1]}; // [RULE1]
                jtapp_pkg::JTAPP_UPD_IR:   ir_reg <= ir_shift_reg;
                default:                   ir_reg <= ir_reg;
            endcase
        end
    end

    // Unknown instructions fall back to the one-bit bypass path
    assign sel_idcode = (ir_reg == `JTAPP_INSN_IDCODE);

    // Data registers: identity word or bypass bit, captured then shifted LSB first [RULE9]
    always_ff @(posedge i_clock or negedge tap_rst_n_reg)
    begin
        if (!tap_rst_n_reg)
        begin
            dr_shift_reg <= '0;
            bypass_reg   <= 1'b0;
        end
        else if (tck_rise)
        begin
            case (state_reg)
                jtapp_pkg::JTAPP_CAP_DR:
                begin
                    dr_shift_reg <= `JTAPP_IDCODE_VALUE;
                    bypass_reg   <= 1'b0;
                end
                jtapp_pkg::JTAPP_SHIFT_DR:
                begin
                    dr_shift_reg <= {tdi_sync, dr_shift_reg[`JTAPP_DR_WIDTH-1:1]}; // [RULE1]
                    bypass_reg   <= tdi_sync; // [RULE1]
                end
                default:
                begin
                    bypass_reg   <= bypass_reg;
                end
            endcase
        end
    end

    // Output source chosen by the scan in progress
    assign shifting = (state_reg == jtapp_pkg::JTAPP_SHIFT_DR) || (state_reg == jtapp_pkg::JTAPP_SHIFT_IR);

    always_comb
    begin
        if (state_reg == jtapp_pkg::JTAPP_SHIFT_IR)
        begin
            tdo_next = ir_shift_reg[0];
        end
        else if (sel_idcode)
        begin
            tdo_next = dr_shift_reg[0];
        end
        else
        begin
            tdo_next = bypass_reg;
        end
    end

    // Output and its enable only change on a falling test clock edge or clear at test reset [RULE4] [RULE5]
    always_ff @(posedge i_clock or negedge tap_rst_n_reg)
    begin
        if (!tap_rst_n_reg)
        begin
            o_tdo    <= 1'b0;
            o_tdo_oe <= 1'b0; // [RULE5]
        end
        else if (tck_fall)
        begin
            o_tdo    <= shifting ? tdo_next : 1'b0; // [RULE4]
            o_tdo_oe <= shifting; // [RULE5]
        end
    end

    // Status flag for the rest of the chip: controller sits in test-logic-reset
    always_ff @(posedge i_clock or negedge tap_rst_n_reg)
    begin
        if (!tap_rst_n_reg)
        begin
            o_tap_reset <= 1'b1;
        end
        else
        begin
            o_tap_reset <= (state_next == jtapp_pkg::JTAPP_TLR) && tck_rise
                           || (state_reg == jtapp_pkg::JTAPP_TLR) && !tck_rise;
        end
    end

endmodule

`default_nettype wire

// [tb/jtapp_ctl_model.sv]
// Model of the outside test controller driving the port pins
`timescale 1ns/100ps
`default_nettype none

module jtapp_ctl_model
(
    input  wire logic i_clock,
    input  wire logic i_tdo,
    output var  logic o_tck,
    output var  logic o_tms,
    output var  logic o_tdi,
    output var  logic o_trst_n
);
    // Test reset low from power-up until scanning starts
    initial
    begin
        o_tck    = 1'h1;
        o_tms    = 1'h1;
        o_tdi    = 1'h1;
        o_trst_n = 1'h0;
    end

    // One 800 ns test clock period; clock idles high between frames
    // Mode and data change with the fall so they sit still across the rise
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        @(posedge i_clock);
        o_tck <= 1'h0;
        o_tms <= tms;
        o_tdi <= tdi;
        repeat (4) @(posedge i_clock);
        tdo = i_tdo;
        o_tck <= 1'h1;
        repeat (3) @(posedge i_clock);
    endtask

    task automatic set_trst(input logic v);
        @(posedge i_clock);
        o_trst_n <= v;
    endtask
endmodule

`default_nettype wire

// [tb/jtapp_tap_monitor.sv]
// Concurrent checks on the test access port pins
`timescale 1ns/100ps
`default_nettype none

module jtapp_tap_monitor
(
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_tck,
    input wire logic i_tms,
    input wire logic i_tdi,
    input wire logic i_trst_n,
    input wire logic o_tdo,
    input wire logic o_tdo_oe,
    input wire logic o_tap_reset
);
    logic       tck_q_reg;
    logic [2:0] ones_reg;

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_reset_n);

    // Run of test clock rises with mode select high, saturating at five
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            tck_q_reg <= 1'h1;
            ones_reg  <= 3'h0;
        end
        else
        begin
            tck_q_reg <= i_tck;
            if (i_tck && !tck_q_reg)
                ones_reg <= !i_tms ? 3'h0 : (ones_reg == 3'h5) ? 3'h5 : ones_reg + 3'h1;
        end
    end

    sequence s_trst_held;
        (!i_trst_n) [*3];
    endsequence

    chk_tdo_on_fall: assert property (i_trst_n && $changed(o_tdo) |-> !i_tck && !$past(i_tck) && $past(i_tck, 4))
        else $error("tdo moved away from a falling test clock");
    chk_oe_on_fall: assert property (i_trst_n && $changed(o_tdo_oe) |-> !i_tck && !$past(i_tck) && $past(i_tck, 4))
        else $error("tdo enable moved away from a falling test clock");
    chk_tdo_released: assert property (!o_tdo_oe |-> o_tdo == 1'h0)
        else $error("tdo not quiet while disabled");
    chk_shift_entry: assert property (i_trst_n && $rose(o_tdo_oe) |-> !$past(i_tms, 4))
        else $error("shift entered with mode select high");
    chk_shift_exit: assert property (i_trst_n && $fell(o_tdo_oe) |-> $past(i_tms, 4))
        else $error("shift left with mode select low");
    chk_leave_reset: assert property ($fell(o_tap_reset) |-> $past(i_tck, 2) && !$past(i_tms, 2))
        else $error("reset state left without a low mode select rise");
    chk_tms_to_reset: assert property (ones_reg == 3'h5 |-> ##[0:4] o_tap_reset)
        else $error("five high mode select rises did not reach reset");
    chk_trst_forces: assert property ($fell(i_trst_n) |-> ##[0:2] o_tap_reset && !o_tdo_oe)
        else $error("test reset did not force the reset state");
    chk_trst_holds: assert property (s_trst_held |-> o_tap_reset && !o_tdo_oe && o_tdo == 1'h0)
        else $error("outputs active during test reset");
    chk_idle_still: assert property ((i_trst_n && $stable(i_tck)) [*6] |-> $stable(o_tdo_oe) && $stable(o_tap_reset))
        else $error("port moved without a test clock edge");
endmodule

bind jtapp_tap jtapp_tap_monitor u_monitor (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_tck(i_tck), .i_tms(i_tms),
    .i_tdi(i_tdi), .i_trst_n(i_trst_n), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .o_tap_reset(o_tap_reset));

`default_nettype wire

// [tb/jtapp_tap_test.sv]
// Self-checking bench for the test access port
`include "jtapp_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module jtapp_tap_test;
    logic        i_clock;
    logic        i_reset_n;
    wire logic   tck, tms, tdi, trst_n, tdo, tdo_oe, tap_reset;
    int          fails;
    int          n_compared;
    logic [31:0] got;
    logic        b;

    jtapp_ctl_model ctl (.i_clock(i_clock), .i_tdo(tdo), .o_tck(tck), .o_tms(tms), .o_tdi(tdi), .o_trst_n(trst_n));
    jtapp_tap DUT (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
        .i_trst_n(trst_n), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .o_tap_reset(tap_reset));

    initial
    begin
        i_clock = 1'h0;
        forever #50 i_clock = ~i_clock;
    end

    task automatic check_vec(input string what, input logic [31:0] exp, input logic [31:0] seen);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Mode bits go lowest first with data low
    task automatic move(input logic [7:0] seq, input int n);
        for (int i = 0; i < n; i++)
            ctl.step(seq[i], 1'h0, b);
    endtask

    // Mode rises on the last bit to leave the shift state
    task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout);
        dout = 32'h0;
        for (int i = 0; i < n; i++)
        begin
            ctl.step(i == n - 1, din[i], dout[i]);
            check_vec("enable in shift", 32'h1, {31'h0, tdo_oe});
        end
    endtask

    task automatic read_id();
        move(8'h02, 4);
        shift(32, 32'h0, got);
        check_vec("identity", `JTAPP_IDCODE_VALUE, got);
        move(8'h01, 2);
        check_vec("released after exit", 32'h0, {30'h0, tdo_oe, tdo});
    endtask

    task automatic t_reset_state();
        check_vec("outputs in reset", 32'h4, {29'h0, tap_reset, tdo_oe, tdo});
        ctl.set_trst(1'h1);
        repeat (6) @(posedge i_clock);
        move(8'h1f, 5);
        check_vec("mode high keeps reset", 32'h4, {29'h0, tap_reset, tdo_oe, tdo});
    endtask

    // Bypass delays data by one bit behind a captured zero
    task automatic t_ir_bypass();
        move(8'h03, 4);
        shift(4, {28'h0, `JTAPP_INSN_BYPASS}, got);
        check_vec("ir capture", {28'h0, `JTAPP_IR_CAPTURE}, got);
        move(8'h05, 5);
        shift(8, 32'h96, got);
        check_vec("bypass path", 32'h2c, got);
        move(8'h01, 2);
    endtask

    task automatic t_trst_abort();
        move(8'h01, 3);
        ctl.step(1'h0, 1'h1, b);
        ctl.set_trst(1'h0);
        repeat (2) @(posedge i_clock);
        check_vec("reset in shift", 32'h4, {29'h0, tap_reset, tdo_oe, tdo});
        ctl.set_trst(1'h1);
        repeat (6) @(posedge i_clock);
    endtask

    task automatic t_tms_reset();
        check_vec("idle not reset", 32'h0, {31'h0, tap_reset});
        move(8'h1f, 5);
        check_vec("five high rises", 32'h1, {31'h0, tap_reset});
    endtask

    task automatic close_out();
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // About 930 cycles expected; over four times that as margin
    initial
    begin
        #400000;
        fails++;
        close_out();
    end

    initial
    begin
        fails = 0;
        n_compared = 0;
        i_reset_n = 1'h0;
        repeat (2) @(posedge i_clock);
        i_reset_n <= 1'h1;
        repeat (4) @(posedge i_clock);
        t_reset_state();
        read_id();
        t_ir_bypass();
        t_trst_abort();
        read_id();
        t_tms_reset();
        close_out();
    end
endmodule

`default_nettype wire
